//--- measurement_channel_config.sv
// Channel A/B configuration registers and per-measurement setting decode
//
// Operation
// - Channel A register is 17 bits: cal select, path, gain, osf, osr, chop, averaging.
// - Channel A resets to current switch closed, gain 11, osf 1, rest zero.
// - Channel B has same layout; resets to switches four and three, gain 01, osf 1.
// - Cal select 0..5 picks voltage constants; 6 and 7 use fixed 1548.
// - Path bit one set closes the shunt current input switch; bits active high.
// - Seven legal path codes select shunt input or voltage bus variants.
// - Gain code gives gain 6, 24, 50 or 100.
// - Oversample bit picks 2.048/4.096 MHz external, 132/264 kHz internal oscillator.
// - Oversample ratio bit picks decimation 64 or 128.
// - Chop ratio bit picks 4 or 8 while chopping or dechopping enabled.
// - With chop and dechop off, every cycle yields a result.
// - Averaging codes 0..10 average two to the code results.
// - Averaging code 15 selects raw mode without calibration or averaging.
// - Raw result scale is two to (11 plus x) over cal constant.
// - Path bit one set picks current constant by gain, else voltage select.
// - Alternating mode makes sequence-length measurements per channel; zero means 16.
// - Chop and dechop enables come from the general configuration register.
`timescale 1ns/100ps
`default_nettype none
module measurement_channel_config
  import chan_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            sys_rst,
  // Register port from the serial interface
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  input  wire logic [3:0]                      reg_addr,
  input  wire logic [CFG_WIDTH-1:0]            reg_wdata,
  output logic      [CFG_WIDTH-1:0]            reg_rdata,
  // General configuration and converter control
  input  wire logic                            chop_en,
  input  wire logic                            dechop_en,
  input  wire logic                            alternating_measure_mode,
  input  wire logic [3:0]                      sequence_length,
  input  wire logic                            single_chan_b,
  input  wire logic                            use_int_osc,
  input  wire logic                            meas_start,
  input  wire logic [CAL_WIDTH*CAL_COUNT-1:0]  cal_constants,
  // Active measurement settings
  output logic                                 active_chan_b,
  output active_cfg_t                          active_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions

  function automatic logic [6:0] gain_value(input logic [1:0] code);
    unique case (code)
      2'h0: gain_value = 7'h06;
      2'h1: gain_value = 7'h18;
      2'h2: gain_value = 7'h32;
      2'h3: gain_value = 7'h64;
    endcase
  endfunction

  function automatic logic [10:0] pick_cal(input chan_cfg_t c, input logic [CAL_WIDTH*CAL_COUNT-1:0] bus);
    logic [3:0] idx;
    idx = 4'h0;
    if (c.path_switch_field[0]) begin
      idx = {2'h0, c.gain_code};
      pick_cal = bus[CAL_WIDTH*(CAL_COUNT-1-int'(idx)) +: CAL_WIDTH];
    end else if (c.voltage_cal_select > VCAL_LAST) begin
      pick_cal = FIXED_CAL;
    end else begin
      idx = 4'(CAL_CAU_BASE) + {1'b0, c.voltage_cal_select};
      pick_cal = bus[CAL_WIDTH*(CAL_COUNT-1-int'(idx)) +: CAL_WIDTH];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers and read-back

  chan_cfg_t         cha_ff;
  chan_cfg_t         chb_ff;
  logic [16:0]       rdata_ff;
  wire logic         wr_a = reg_wr && (reg_addr == ADDR_CHANNEL_A);
  wire logic         wr_b = reg_wr && (reg_addr == ADDR_CHANNEL_B);
  wire logic [16:0]  nxt_rdata = (reg_addr == ADDR_CHANNEL_A) ? cha_ff :
                                 (reg_addr == ADDR_CHANNEL_B) ? chb_ff : 17'h0_0000;

  // Path codes are stored as written; illegal codes are software's responsibility
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cha_ff <= CHA_RESET;
      chb_ff <= CHB_RESET;
    end else begin
      if (wr_a) cha_ff <= reg_wdata;
      if (wr_b) chb_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) rdata_ff <= 17'h0_0000;
    else if (reg_rd) rdata_ff <= nxt_rdata;
  end
  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Channel sequencing

  logic              alt_chan_ff;
  logic [4:0]        seq_cnt_ff;
  wire logic [4:0]   seq_len = (sequence_length == 4'h0) ? SEQ_ZERO_LEN : {1'b0, sequence_length};
  wire logic         seq_done = (seq_cnt_ff + 5'h01) >= seq_len;
  wire logic         use_b = alternating_measure_mode ? alt_chan_ff : single_chan_b;
  wire chan_cfg_t    sel_cfg = use_b ? chb_ff : cha_ff;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alt_chan_ff <= 1'b0;
      seq_cnt_ff  <= 5'h00;
    end else if (!alternating_measure_mode) begin
      alt_chan_ff <= 1'b0;
      seq_cnt_ff  <= 5'h00;
    end else if (meas_start) begin
      alt_chan_ff <= seq_done ? !alt_chan_ff : alt_chan_ff;
      seq_cnt_ff  <= seq_done ? 5'h00 : seq_cnt_ff + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the selected channel settings

  active_cfg_t       nxt_active;
  active_cfg_t       active_ff;
  logic              chan_b_ff;
  wire logic         raw_sel = sel_cfg.averaging_code == AVG_RAW_CODE;
  wire logic         chop_any = chop_en || dechop_en;

  always_comb begin
    nxt_active               = '0;
    nxt_active.path_switches = sel_cfg.path_switch_field;
    nxt_active.gain_value    = gain_value(sel_cfg.gain_code);
    nxt_active.mod_rate_khz  = use_int_osc ? (sel_cfg.oversample_freq_field ? RATE_INT_FAST : RATE_INT_SLOW)
                                           : (sel_cfg.oversample_freq_field ? RATE_EXT_FAST : RATE_EXT_SLOW);
    nxt_active.decim_ratio   = sel_cfg.oversample_ratio_field ? DECIM_HIGH : DECIM_LOW;
    nxt_active.chop_ratio    = !chop_any ? CHOP_OFF :
                               (sel_cfg.chop_ratio_field ? CHOP_HIGH : CHOP_LOW);
    nxt_active.avg_count     = (sel_cfg.averaging_code <= AVG_MAX_CODE) ?
                               11'h001 << sel_cfg.averaging_code : 11'h001;
    nxt_active.raw_mode      = raw_sel;
    nxt_active.raw_exp       = RAW_EXP_BASE + (sel_cfg.oversample_ratio_field ? RAW_X_R128 : RAW_X_R64);
    nxt_active.cal_const     = pick_cal(sel_cfg, cal_constants);
  end

  // Latching at measurement start keeps a conversion from seeing a half-applied write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_ff <= '0;
      chan_b_ff <= 1'b0;
    end else if (meas_start) begin
      active_ff <= nxt_active;
      chan_b_ff <= use_b;
    end
  end
  assign active_cfg    = active_ff;
  assign active_chan_b = chan_b_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_reg_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_a |=> cha_ff == $past(reg_wdata)) else $error("channel A write lost");
  a_reg_write_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_b |=> chb_ff == $past(reg_wdata)) else $error("channel B write lost");
  a_read_back_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_CHANNEL_A |=> reg_rdata == $past(cha_ff)) else $error("channel A read wrong");
  a_read_back_b: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_CHANNEL_B |=> reg_rdata == $past(chb_ff)) else $error("channel B read wrong");
  a_active_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !meas_start |=> $stable(active_ff)) else $error("settings changed mid measurement");
  a_path_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start |=> active_ff.path_switches == $past(sel_cfg.path_switch_field))
    else $error("path switches wrong");
  a_gain_map: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && sel_cfg.gain_code == 2'h2 |=> active_ff.gain_value == 7'h32) else $error("gain decode wrong");
  a_gain_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && sel_cfg.gain_code == 2'h0 |=> active_ff.gain_value == 7'h06) else $error("gain six wrong");
  a_ext_rate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && !use_int_osc
    |=> active_ff.mod_rate_khz == ($past(sel_cfg.oversample_freq_field) ? 13'h1000 : 13'h0800))
    else $error("external rate wrong");
  a_int_fast: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && use_int_osc && sel_cfg.oversample_freq_field |=> active_ff.mod_rate_khz == 13'h0108)
    else $error("internal fast rate wrong");
  a_decim_ratio: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start |=> active_ff.decim_ratio == ($past(sel_cfg.oversample_ratio_field) ? 8'h80 : 8'h40))
    else $error("decimation ratio wrong");
  a_chop_ratio: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && (chop_en || dechop_en) |=> active_ff.chop_ratio == ($past(sel_cfg.chop_ratio_field) ? 4'h8 : 4'h4))
    else $error("chop ratio wrong");
  a_chop_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && !chop_en && !dechop_en |=> active_ff.chop_ratio == 4'h1) else $error("chop ratio not 1");
  a_avg_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && sel_cfg.averaging_code == 4'hA |=> active_ff.avg_count == 11'h400) else $error("avg count wrong");
  a_avg_single: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && sel_cfg.averaging_code == 4'h0 |=> active_ff.avg_count == 11'h001)
    else $error("single average wrong");
  a_raw_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start |=> active_ff.raw_mode == ($past(sel_cfg.averaging_code) == 4'hF)) else $error("raw mode wrong");
  a_raw_exp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && sel_cfg.oversample_ratio_field |=> active_ff.raw_exp == 5'h11) else $error("raw exponent wrong");
  a_raw_exp_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && !sel_cfg.oversample_ratio_field |=> active_ff.raw_exp == 5'h0E)
    else $error("low raw exponent wrong");
  a_fixed_cal: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && !sel_cfg.path_switch_field[0] && sel_cfg.voltage_cal_select[2:1] == 2'h3
    |=> active_ff.cal_const == 11'h60C) else $error("fixed cal not applied");
  a_voltage_cal: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && !sel_cfg.path_switch_field[0] && sel_cfg.voltage_cal_select == 3'h5
    |=> active_ff.cal_const == $past(cal_constants[10:0])) else $error("voltage constant wrong");
  a_current_cal: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && sel_cfg.path_switch_field[0] && sel_cfg.gain_code == 2'h0
    |=> active_ff.cal_const == $past(cal_constants[109:99])) else $error("current constant wrong");
  a_seq_switch: assert property (@(posedge ref_clk) disable iff (sys_rst)
    alternating_measure_mode && meas_start && sequence_length == 4'h1 |=> alt_chan_ff != $past(alt_chan_ff))
    else $error("sequence did not alternate");
  a_alt_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !alternating_measure_mode |=> !alt_chan_ff && seq_cnt_ff == 5'h00) else $error("alternation not reset");
  a_single_chan: assert property (@(posedge ref_clk) disable iff (sys_rst)
    meas_start && !alternating_measure_mode |=> active_chan_b == $past(single_chan_b))
    else $error("channel select wrong");

endmodule
`default_nettype wire

//--- chan_cfg_pkg.sv
// Package: register map, field layout and decode constants for the channel configuration block
package chan_cfg_pkg;

  // Register addresses on the serial register port
  localparam logic [3:0]  ADDR_CHANNEL_A  = 4'h1;
  localparam logic [3:0]  ADDR_CHANNEL_B  = 4'h2;

  // Field positions inside a 17-bit channel register
  localparam int          CFG_WIDTH       = 17;
  localparam int          POS_VCAL_SEL    = 14;
  localparam int          POS_PATH        = 9;
  localparam int          POS_GAIN        = 7;
  localparam int          POS_OSF         = 6;
  localparam int          POS_OSR         = 5;
  localparam int          POS_CHOP_RATIO  = 4;
  localparam int          POS_AVG         = 0;

  // Power-up values
  localparam logic [16:0] CHA_RESET       = 17'h0_03C0;
  localparam logic [16:0] CHB_RESET       = 17'h0_18C0;

  // Calibration
  localparam int          CAL_WIDTH       = 11;
  localparam int          CAL_COUNT       = 10;
  localparam logic [10:0] FIXED_CAL       = 11'h60C;
  localparam logic [2:0]  VCAL_LAST       = 3'h5;
  localparam int          CAL_CAU_BASE    = 4;

  // Averaging codes
  localparam logic [3:0]  AVG_MAX_CODE    = 4'hA;
  localparam logic [3:0]  AVG_RAW_CODE    = 4'hF;

  // Raw scaling exponent 11 + x
  localparam logic [4:0]  RAW_EXP_BASE    = 5'h0B;
  localparam logic [4:0]  RAW_X_R128      = 5'h06;
  localparam logic [4:0]  RAW_X_R64       = 5'h03;

  // Decimation, chopping and modulator rates (kHz)
  localparam logic [7:0]  DECIM_LOW       = 8'h40;
  localparam logic [7:0]  DECIM_HIGH      = 8'h80;
  localparam logic [3:0]  CHOP_LOW        = 4'h4;
  localparam logic [3:0]  CHOP_HIGH       = 4'h8;
  localparam logic [3:0]  CHOP_OFF        = 4'h1;
  localparam logic [12:0] RATE_EXT_SLOW   = 13'h0800;
  localparam logic [12:0] RATE_EXT_FAST   = 13'h1000;
  localparam logic [12:0] RATE_INT_SLOW   = 13'h0084;
  localparam logic [12:0] RATE_INT_FAST   = 13'h0108;

  // Sequence length
  localparam logic [4:0]  SEQ_ZERO_LEN    = 5'h10;

  typedef struct packed {
    logic [2:0] voltage_cal_select;
    logic [4:0] path_switch_field;
    logic [1:0] gain_code;
    logic       oversample_freq_field;
    logic       oversample_ratio_field;
    logic       chop_ratio_field;
    logic [3:0] averaging_code;
  } chan_cfg_t;

  typedef struct packed {
    logic [4:0]  path_switches;
    logic [6:0]  gain_value;
    logic [12:0] mod_rate_khz;
    logic [7:0]  decim_ratio;
    logic [3:0]  chop_ratio;
    logic [10:0] avg_count;
    logic        raw_mode;
    logic [4:0]  raw_exp;
    logic [10:0] cal_const;
  } active_cfg_t;

endpackage

//--- host_model.sv
// Host model that issues register writes and reads on the register port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic        ref_clk,
  // Register port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [3:0]       reg_addr,
  output logic [16:0]      reg_wdata,
  input  wire logic [16:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Callers pass listed path codes only, no test averaging codes, B current switch clear
  task automatic wr_reg(logic [3:0] a, logic [16:0] d);
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge ref_clk);
    #1;
    // Released lines flip so a stale value is never mistaken for a live one
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [16:0] d);
    @(posedge ref_clk);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge ref_clk);
    #1;
    d = reg_rdata;
    {reg_rd, reg_addr} = {1'b0, ~a};
  endtask
endmodule
`default_nettype wire

//--- tb_measurement_channel_config.sv
// Self-checking testbench for the channel configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_measurement_channel_config;
  import chan_cfg_pkg::*;
  logic ref_clk = 0, sys_rst = 1, chop_en = 1, dechop_en = 0, alt = 0;
  logic single_b = 0, int_osc = 0, meas_start = 0, reg_wr, reg_rd, active_chan_b;
  logic [3:0] seq_len = 4'h2, reg_addr;
  logic [16:0] reg_wdata, reg_rdata, rd_val;
  logic [109:0] cal = '0;
  active_cfg_t active_cfg;
  chan_cfg_t ca, cb;
  logic [4:0] paths [7] = '{5'h01, 5'h08, 5'h0A, 5'h0C, 5'h10, 5'h12, 5'h14};
  int err_count = 0, tests_run = 0;
  always #4 ref_clk = ~ref_clk;
  host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  measurement_channel_config uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .chop_en(chop_en), .dechop_en(dechop_en), .alternating_measure_mode(alt),
    .sequence_length(seq_len), .single_chan_b(single_b), .use_int_osc(int_osc),
    .meas_start(meas_start), .cal_constants(cal), .active_chan_b(active_chan_b),
    .active_cfg(active_cfg));
  // Distinct constants so a wrong slot selection always shows
  function automatic logic [10:0] cal_k(int k);
    return 11'h100 + 11'(k);
  endfunction
  function automatic active_cfg_t expect_cfg(chan_cfg_t v);
    active_cfg_t e;
    logic [1:0] g;
    g = v.gain_code;
    e.path_switches = v.path_switch_field;
    e.gain_value = g[1] ? (g[0] ? 7'h64 : 7'h32) : (g[0] ? 7'h18 : 7'h06);
    e.mod_rate_khz = v.oversample_freq_field ? (int_osc ? 13'h0108 : 13'h1000) :
      (int_osc ? 13'h0084 : 13'h0800);
    e.decim_ratio = v.oversample_ratio_field ? 8'h80 : 8'h40;
    e.chop_ratio = (chop_en | dechop_en) ? (v.chop_ratio_field ? 4'h8 : 4'h4) : 4'h1;
    e.avg_count = (v.averaging_code <= 4'hA) ? 11'h001 << v.averaging_code : 11'h001;
    e.raw_mode = (v.averaging_code == 4'hF);
    e.raw_exp = v.oversample_ratio_field ? 5'h11 : 5'h0E;
    e.cal_const = v.path_switch_field[0] ? cal_k(int'(g)) :
      (v.voltage_cal_select <= 3'h5) ? cal_k(4 + int'(v.voltage_cal_select)) : 11'h60C;
    return e;
  endfunction
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_word(logic [16:0] exp, logic [16:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg(chan_cfg_t v, logic b, logic go);
    if (go) begin
      tick();
      meas_start = 1;
      tick();
      meas_start = 0;
    end
    tests_run++;
    if (active_cfg !== expect_cfg(v) || active_chan_b !== b) begin
      err_count++;
      $display("CHECK FAILED at %0t: settings %h chan %b", $time, active_cfg, active_chan_b);
    end
  endtask
  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  initial begin
    for (int k = 0; k < 10; k++)
      cal[(9 - k) * 11 +: 11] = cal_k(k);
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 0;
    ca = {3'h0, 5'h01, 2'h3, 1'b1, 1'b0, 1'b0, 4'h0};
    cb = {3'h0, 5'h0C, 2'h1, 1'b1, 1'b0, 1'b0, 4'h0};
    host.wr_reg(4'h3, 17'h1_FFFF);
    host.rd_reg(4'h1, rd_val);
    chk_word(ca, rd_val);
    host.rd_reg(4'h2, rd_val);
    chk_word(cb, rd_val);
    host.rd_reg(4'h3, rd_val);
    chk_word(17'h0_0000, rd_val);
    chk_cfg(ca, 1'b0, 1'b1);
    $display("test reset values done");
    // Sweeps every path code, gain, cal select and averaging code 0..10
    for (int k = 0; k < 28; k++) begin
      ca = {3'(k), paths[k % 7], 2'(k / 7), 1'(k / 2), 1'(k / 3), 1'(k), 4'(k % 11)};
      host.wr_reg(4'h1, ca);
      host.rd_reg(4'h1, rd_val);
      chk_word(ca, rd_val);
      chk_cfg(ca, 1'b0, 1'b1);
    end
    $display("test field decode done");
    single_b = 1;
    cb = {3'h2, 5'h12, 2'h2, 1'b0, 1'b1, 1'b1, 4'hF};
    host.wr_reg(4'h2, cb);
    chk_cfg(cb, 1'b1, 1'b1);
    ca = cb;
    cb.oversample_ratio_field = 1'b0;
    host.wr_reg(4'h2, cb);
    chk_cfg(ca, 1'b1, 1'b0);
    chk_cfg(cb, 1'b1, 1'b1);
    $display("test raw mode done");
    host.wr_reg(4'h1, ca);
    alt = 1;
    chop_en = 0;
    int_osc = 1;
    for (int k = 0; k < 5; k++)
      chk_cfg((k % 4 < 2) ? ca : cb, 1'(k % 4 >= 2), 1'b1);
    // Length one flips every start; dechop alone must still give the 4/8 ratio
    seq_len = 4'h1;
    dechop_en = 1;
    ca.oversample_freq_field = 1'b1;
    host.wr_reg(4'h1, ca);
    for (int k = 0; k < 4; k++)
      chk_cfg(k[0] ? cb : ca, k[0], 1'b1);
    // Code zero stands for sixteen starts per channel
    seq_len = 4'h0;
    for (int k = 0; k < 17; k++)
      chk_cfg((k < 16) ? ca : cb, 1'(k >= 16), 1'b1);
    $display("test alternation done");
    close_out();
  end
endmodule
`default_nettype wire
